// ### rtl/ioc_regs.vh
/*
 * Register map, field positions, reset values and mode codes of the
 * programmable I/O cell pair.
 * Assumes inclusion by bare name from the cell's top module.
 */
`ifndef IOC_REGS_VH
`define IOC_REGS_VH

// ********************
// Register byte addresses
// ********************
`define IOC_ADDR_CTRL       12'h000
`define IOC_ADDR_INIT       12'h004
`define IOC_ADDR_STATUS     12'h008

// ********************
// Reset values and widths
// ********************
`define IOC_CTRL_W          18
`define IOC_CTRL_RST        18'h00000
`define IOC_INIT_W          3
`define IOC_INIT_RST        3'h0

// ********************
// Control field positions
// ********************
`define IOC_F_IN_MODE_LO    0
`define IOC_F_IN_MODE_HI    1
`define IOC_F_CLK_SEL_LO    2
`define IOC_F_CLK_SEL_HI    3
`define IOC_F_CLK_INV       4
`define IOC_F_DLY_EN        5
`define IOC_F_DLY_DYN       6
`define IOC_F_DLY_FIX_LO    7
`define IOC_F_DLY_FIX_HI    10
`define IOC_F_OUT_MODE_LO   11
`define IOC_F_OUT_MODE_HI   12
`define IOC_F_OUT_LATCH     13
`define IOC_F_TRI_DDR       14
`define IOC_F_TRI_LATCH     15
`define IOC_F_DIFF          16
`define IOC_F_POL_AUTO      17

// ********************
// Init field positions
// ********************
`define IOC_F_INIT_IN       0
`define IOC_F_INIT_OUT      1
`define IOC_F_INIT_TRI      2

// ********************
// Mode codes
// ********************
`define IOC_IN_SDR          2'h0
`define IOC_IN_DDR          2'h1
`define IOC_IN_GEAR         2'h2
`define IOC_IN_BYPASS       2'h3
`define IOC_OUT_SDR         2'h0
`define IOC_OUT_DDR         2'h1
`define IOC_OUT_GEAR        2'h2

// ********************
// Delay line
// ********************
`define IOC_DLY_TAPS        16

`endif

// ### rtl/ioc_top.v
/*
 * Programmable I/O cell pair: input, output and tristate register
 * paths, clock selection, input delay, gearbox and APB registers.
 * Assumes pads, edge clocks and strobe arrive asynchronously and are
 * sampled by I_SYS_CLK; core-side controls share I_SYS_CLK.
 */
// The register offsets and the APB interface to the registers were decided locally.
// Operation
// - Cell holds two pin units, each with output, tristate and pad input.
// - Two units join as true/complement pair; LVDS out where capable.
// - Pad input may bypass registers and delay to core, clock, strobe.
// - Input delay is fixed or set by a four-bit core bus.
// - SDR input mode captures pad data in one register on cell clock.
// - DDR input samples rise and fall strobe edges, resynced to system.
// - Registered input shows data captured on selected clock rising edge.
// - Polarity control picks system clock edge for strobe resync.
// - Pair gearbox turns double-rate input of unit A into four streams.
// - SDR output passes negative data through flip-flop or latch.
// - DDR output registers both bits; positive bit latched, clock mux.
// - Double-rate output exists only on left, right and bottom edges.
// - Pair gearbox serialises four core streams onto the pad.
// - SDR tristate passes core control through flip-flop or latch.
// - DDR tristate registers both bits; positive latched, clock mux.
// - Input clock chosen from routing, two edge clocks or strobe.
// - Selected input clock may be inverted.
// - Core clock enables gate flops; local set/reset acts on cell.
// - Active-low global set/reset acts on cell registers.
// - Strobe leaving idle into preamble sets sync clock polarity.
`include "ioc_regs.vh"

module ioc_top #(
    parameter EDGE_LRB     = 1,
    parameter LVDS_CAPABLE = 1
) (
    // System
    input  wire         I_SYS_CLK,
    input  wire         I_SYS_RST,
    // APB slave
    input  wire         I_PSEL,
    input  wire         I_PENABLE,
    input  wire         I_PWRITE,
    input  wire [11:0]  I_PADDR,
    input  wire [31:0]  I_PWDATA,
    output wire [31:0]  O_PRDATA,
    output wire         O_PREADY,
    output wire         O_PSLVERR,
    // Pads
    input  wire [1:0]   I_PAD_INPUT,
    output wire [1:0]   O_PAD_OUT,
    output wire [1:0]   O_PAD_OE,
    // Clock sources
    input  wire         I_CLK_ROUTE,
    input  wire         I_EDGE_CLOCK_ONE,
    input  wire         I_EDGE_CLOCK_TWO,
    input  wire         I_STROBE,
    input  wire         I_STROBE_IDLE,
    // Core controls
    input  wire [3:0]   I_DYNAMIC_DELAY_CTRL,
    input  wire         I_SYNC_CLOCK_POLARITY,
    input  wire         I_CE_IN,
    input  wire         I_CE_OUT,
    input  wire         I_LOCAL_SET_RESET,
    input  wire         I_GLOBAL_SET_RESET_N,
    // Core output data
    input  wire [1:0]   I_OUT_DATA_NEG,
    input  wire [1:0]   I_OUT_DATA_POS,
    input  wire [1:0]   I_TRI_CTRL_NEG,
    input  wire [1:0]   I_TRI_CTRL_POS,
    input  wire [1:0]   I_SDR_TRI_CTRL,
    input  wire [3:0]   I_GEAR_OUT_DATA,
    // Inputs to core
    output wire [1:0]   O_COMB_INPUT_TO_CORE,
    output wire [1:0]   O_CLOCK_NETWORK_INPUT,
    output wire         O_STROBE_DELAY_FEED,
    output wire [1:0]   O_REGISTERED_INPUT,
    output wire [1:0]   O_DUAL_RATE_INPUT_A,
    output wire [1:0]   O_DUAL_RATE_INPUT_B,
    output wire [1:0]   O_GEARBOX_POS_INPUT,
    output wire [1:0]   O_GEARBOX_NEG_INPUT
);

// ********************
// Input synchronisers
// ********************
    localparam SW = 7;
    localparam SI_ROUTE = 2;
    localparam SI_E1    = 3;
    localparam SI_E2    = 4;
    localparam SI_STB   = 5;
    localparam SI_IDLE  = 6;

    reg  [SW-1:0]  sync1_q;
    reg  [SW-1:0]  sync2_q;
    wire [SW-1:0]  raw_in;

    assign raw_in = {I_STROBE_IDLE, I_STROBE, I_EDGE_CLOCK_TWO,
                     I_EDGE_CLOCK_ONE, I_CLK_ROUTE, I_PAD_INPUT};

    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            sync1_q <= {SW{1'b0}};
            sync2_q <= {SW{1'b0}};
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

// ********************
// Registers
// ********************
    reg  [`IOC_CTRL_W-1:0]  ctrl_q;
    reg  [`IOC_INIT_W-1:0]  init_q;
    reg  [31:0]             prdata_q;
    reg                     pslverr_q;
    reg  [31:0]             rd_d;
    reg                     err_d;
    wire [31:0]             status;
    wire                    wr_en;

    wire [1:0] in_mode  = ctrl_q[`IOC_F_IN_MODE_HI:`IOC_F_IN_MODE_LO];
    wire [1:0] clk_sel  = ctrl_q[`IOC_F_CLK_SEL_HI:`IOC_F_CLK_SEL_LO];
    wire [1:0] out_mode = ctrl_q[`IOC_F_OUT_MODE_HI:`IOC_F_OUT_MODE_LO];
    wire [3:0] dly_fix  = ctrl_q[`IOC_F_DLY_FIX_HI:`IOC_F_DLY_FIX_LO];

    assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
    assign O_PREADY  = I_PSEL & I_PENABLE;
    assign O_PRDATA  = prdata_q;
    assign O_PSLVERR = pslverr_q;

    always @* begin
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        if (I_PADDR == `IOC_ADDR_CTRL) begin
            rd_d = {{(32-`IOC_CTRL_W){1'b0}}, ctrl_q};
        end else if (I_PADDR == `IOC_ADDR_INIT) begin
            rd_d = {{(32-`IOC_INIT_W){1'b0}}, init_q};
        end else if (I_PADDR == `IOC_ADDR_STATUS) begin
            rd_d = status;
        end else begin
            err_d = 1'b1;
        end
    end

    // Read data and error are settled in the setup cycle
    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            ctrl_q    <= `IOC_CTRL_RST;
            init_q    <= `IOC_INIT_RST;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            if (I_PSEL & ~I_PENABLE) begin
                prdata_q  <= I_PWRITE ? 32'h00000000 : rd_d;
                pslverr_q <= err_d;
            end
            if (wr_en && I_PADDR == `IOC_ADDR_CTRL) begin
                ctrl_q <= I_PWDATA[`IOC_CTRL_W-1:0];
            end else if (wr_en && I_PADDR == `IOC_ADDR_INIT) begin
                init_q <= I_PWDATA[`IOC_INIT_W-1:0];
            end
        end
    end

// ********************
// Clock selection and edge detection
// ********************
    wire [3:0] clk_src;
    wire       cell_clk;
    wire       cell_rise;
    wire       cell_fall;
    wire       rclk;
    wire       r_rise;
    wire       r_fall;
    reg        cell_clk_q;
    reg        rclk_q;

    assign clk_src  = {sync2_q[SI_STB], sync2_q[SI_E2],
                       sync2_q[SI_E1], sync2_q[SI_ROUTE]};
    assign cell_clk = clk_src[clk_sel] ^ ctrl_q[`IOC_F_CLK_INV];
    assign cell_rise = cell_clk & ~cell_clk_q;
    assign cell_fall = ~cell_clk & cell_clk_q;
    assign rclk   = sync2_q[SI_ROUTE];
    assign r_rise = rclk & ~rclk_q;
    assign r_fall = ~rclk & rclk_q;

    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            cell_clk_q <= 1'b0;
            rclk_q     <= 1'b0;
        end else begin
            cell_clk_q <= cell_clk;
            rclk_q     <= rclk;
        end
    end

// ********************
// Set/reset and resync polarity
// ********************
    wire init_load;
    wire pol;
    wire preamble;
    reg  idle_q;
    reg  pol_auto_q;

    assign init_load = ~I_GLOBAL_SET_RESET_N | I_LOCAL_SET_RESET;
    // Strobe leaves termination level and is driven low
    assign preamble = idle_q & ~sync2_q[SI_IDLE] & ~sync2_q[SI_STB];
    assign pol = ctrl_q[`IOC_F_POL_AUTO] ? pol_auto_q
                                         : I_SYNC_CLOCK_POLARITY;

    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            idle_q     <= 1'b0;
            pol_auto_q <= 1'b0;
        end else begin
            idle_q <= sync2_q[SI_IDLE];
            if (preamble) begin
                pol_auto_q <= rclk;
            end
        end
    end

    // Resync edge of the routing clock (rclk) chosen by polarity
    wire rs_edge = pol ? r_fall : r_rise;

// ********************
// Per pin unit input and output paths
// ********************
    wire [1:0] path_out [0:1];
    wire [1:0] rise_rs;
    wire [1:0] fall_rs;
    wire [1:0] reg_in;
    wire [1:0] pad_s;
    wire       ddr_cap  = (in_mode == `IOC_IN_DDR) |
                          ((in_mode == `IOC_IN_GEAR) & (EDGE_LRB != 0));
    wire       gear_out = (out_mode == `IOC_OUT_GEAR) & (EDGE_LRB != 0);

    genvar u;
    genvar p;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            reg  [`IOC_DLY_TAPS-1:0] dly_q;
            reg                      sdr_q;
            reg                      rise_q;
            reg                      fall_q;
            reg                      rs_rise_q;
            reg                      rs_fall_q;
            wire [3:0]               tap;
            wire                     din;

            assign pad_s[u] = sync2_q[u];
            assign tap = ctrl_q[`IOC_F_DLY_DYN] ? I_DYNAMIC_DELAY_CTRL
                                                : dly_fix;
            assign din = ctrl_q[`IOC_F_DLY_EN] ? dly_q[tap] : pad_s[u];

            always @(posedge I_SYS_CLK) begin
                if (I_SYS_RST) begin
                    dly_q     <= {`IOC_DLY_TAPS{1'b0}};
                    sdr_q     <= 1'b0;
                    rise_q    <= 1'b0;
                    fall_q    <= 1'b0;
                    rs_rise_q <= 1'b0;
                    rs_fall_q <= 1'b0;
                end else begin
                    dly_q <= {dly_q[`IOC_DLY_TAPS-2:0], pad_s[u]};
                    if (init_load) begin
                        sdr_q     <= init_q[`IOC_F_INIT_IN];
                        rise_q    <= init_q[`IOC_F_INIT_IN];
                        fall_q    <= init_q[`IOC_F_INIT_IN];
                        rs_rise_q <= init_q[`IOC_F_INIT_IN];
                        rs_fall_q <= init_q[`IOC_F_INIT_IN];
                    end else if (I_CE_IN) begin
                        if (in_mode == `IOC_IN_SDR && cell_rise) begin
                            sdr_q <= din;
                        end
                        if (ddr_cap && cell_rise) begin
                            rise_q <= din;
                        end
                        if (ddr_cap && cell_fall) begin
                            fall_q <= din;
                        end
                        if (ddr_cap && rs_edge) begin
                            rs_rise_q <= rise_q;
                            rs_fall_q <= fall_q;
                        end
                    end
                end
            end

            assign reg_in[u]  = sdr_q;
            assign rise_rs[u] = rs_rise_q;
            assign fall_rs[u] = rs_fall_q;

            // Path 0 is output data, path 1 is tristate control
            for (p = 0; p < 2; p = p + 1) begin : g_path
                reg  neg_q;
                reg  pos_q;
                reg  pos_lat_q;
                wire sdr_src = (p == 0) ? I_OUT_DATA_NEG[u]
                                        : I_SDR_TRI_CTRL[u];
                wire neg_src = (p == 0) ? I_OUT_DATA_NEG[u]
                                        : I_TRI_CTRL_NEG[u];
                wire pos_src = (p == 0) ? I_OUT_DATA_POS[u]
                                        : I_TRI_CTRL_POS[u];
                wire ddr = (EDGE_LRB != 0) & ((p == 0) ?
                           (out_mode == `IOC_OUT_DDR) :
                           ctrl_q[`IOC_F_TRI_DDR]);
                wire latch = (p == 0) ? ctrl_q[`IOC_F_OUT_LATCH]
                                      : ctrl_q[`IOC_F_TRI_LATCH];
                wire ival = (p == 0) ? init_q[`IOC_F_INIT_OUT]
                                     : init_q[`IOC_F_INIT_TRI];

                always @(posedge I_SYS_CLK) begin
                    if (I_SYS_RST) begin
                        neg_q     <= 1'b0;
                        pos_q     <= 1'b0;
                        pos_lat_q <= 1'b0;
                    end else if (init_load) begin
                        neg_q     <= ival;
                        pos_q     <= ival;
                        pos_lat_q <= ival;
                    end else if (I_CE_OUT) begin
                        if (ddr) begin
                            if (r_rise) begin
                                neg_q <= neg_src;
                                pos_q <= pos_src;
                            end
                            if (r_fall) begin
                                pos_lat_q <= pos_q;
                            end
                        end else if (latch ? rclk : r_rise) begin
                            neg_q <= sdr_src;
                        end
                    end
                end

                // Clock-driven mux picks the stored bit in DDR mode
                assign path_out[u][p] = (ddr & ~rclk) ? pos_lat_q
                                                      : neg_q;
            end
        end
    endgenerate

    assign O_COMB_INPUT_TO_CORE  = pad_s;
    assign O_CLOCK_NETWORK_INPUT = pad_s;
    assign O_STROBE_DELAY_FEED   = pad_s[0];
    assign O_REGISTERED_INPUT    = reg_in;
    assign O_DUAL_RATE_INPUT_A   = {fall_rs[0], rise_rs[0]};
    assign O_DUAL_RATE_INPUT_B   = {fall_rs[1], rise_rs[1]};

// ********************
// Input gearbox: two resynced pairs of unit A into four streams
// ********************
    reg        gin_ph_q;
    reg  [1:0] gin_hold_q;
    reg  [1:0] gpos_q;
    reg  [1:0] gneg_q;
    wire       gin_en = (in_mode == `IOC_IN_GEAR) & (EDGE_LRB != 0);

    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            gin_ph_q   <= 1'b0;
            gin_hold_q <= 2'h0;
            gpos_q     <= 2'h0;
            gneg_q     <= 2'h0;
        end else if (init_load) begin
            gin_ph_q   <= 1'b0;
            gin_hold_q <= {2{init_q[`IOC_F_INIT_IN]}};
            gpos_q     <= {2{init_q[`IOC_F_INIT_IN]}};
            gneg_q     <= {2{init_q[`IOC_F_INIT_IN]}};
        end else if (gin_en && I_CE_IN && rs_edge) begin
            gin_ph_q <= ~gin_ph_q;
            if (!gin_ph_q) begin
                gin_hold_q <= {g_unit[0].fall_q, g_unit[0].rise_q};
            end else begin
                gpos_q <= {g_unit[0].rise_q, gin_hold_q[0]};
                gneg_q <= {g_unit[0].fall_q, gin_hold_q[1]};
            end
        end
    end

    assign O_GEARBOX_POS_INPUT = gpos_q;
    assign O_GEARBOX_NEG_INPUT = gneg_q;

// ********************
// Output gearbox: four core streams serialised on unit A
// ********************
    reg        gout_ph_q;
    reg  [3:0] gser_q;

    always @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            gout_ph_q <= 1'b0;
            gser_q    <= 4'h0;
        end else if (init_load) begin
            gout_ph_q <= 1'b0;
            gser_q    <= {4{init_q[`IOC_F_INIT_OUT]}};
        end else if (gear_out && I_CE_OUT) begin
            if (r_rise && !gout_ph_q) begin
                gser_q    <= I_GEAR_OUT_DATA;
                gout_ph_q <= 1'b1;
            end else if (r_rise || r_fall) begin
                gser_q <= {1'b0, gser_q[3:1]};
                if (r_rise) begin
                    gout_ph_q <= 1'b0;
                end
            end
        end
    end

// ********************
// Pad drive and differential pairing
// ********************
    wire out_a = gear_out ? gser_q[0] : path_out[0][0];
    wire diff  = ctrl_q[`IOC_F_DIFF] & (LVDS_CAPABLE != 0);

    assign O_PAD_OUT[0] = out_a;
    assign O_PAD_OE[0]  = ~path_out[0][1];
    assign O_PAD_OUT[1] = diff ? ~out_a : path_out[1][0];
    assign O_PAD_OE[1]  = diff ? ~path_out[0][1] : ~path_out[1][1];

// ********************
// Status word
// ********************
    assign status = {20'h00000,
                     (LVDS_CAPABLE != 0), (EDGE_LRB != 0),
                     pad_s, pol_auto_q, pol,
                     fall_rs[1], rise_rs[1], fall_rs[0], rise_rs[0],
                     reg_in};

endmodule

// ### bench/ioc_top_props.sv
/* Port checker for the I/O cell pair.
   Bound to ioc_top from the bench top; sees only its ports. */
module ioc_top_props (
    // System
    input logic        I_SYS_CLK,
    input logic        I_SYS_RST,
    // APB
    input logic        I_PSEL,
    input logic        I_PENABLE,
    input logic [11:0] I_PADDR,
    input logic [31:0] O_PRDATA,
    input logic        O_PREADY,
    input logic        O_PSLVERR,
    // Pads and core
    input logic [1:0]  I_PAD_INPUT,
    input logic [1:0]  O_PAD_OUT,
    input logic [1:0]  O_PAD_OE,
    input logic        I_CE_IN,
    input logic        I_LOCAL_SET_RESET,
    input logic        I_GLOBAL_SET_RESET_N,
    input logic [1:0]  O_COMB_INPUT_TO_CORE,
    input logic [1:0]  O_CLOCK_NETWORK_INPUT,
    input logic        O_STROBE_DELAY_FEED,
    input logic [1:0]  O_REGISTERED_INPUT,
    input logic [1:0]  O_DUAL_RATE_INPUT_A
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] rc_q;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ****************************************
    // Cycles since reset, saturating at 3
    // ****************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST)
            rc_q <= 2'h0;
        else if (rc_q != 2'h3)
            rc_q <= rc_q + 2'h1;
    end
    // ****************************************
    // Properties
    // ****************************************
    pready_follow_a: assert property (O_PREADY == (I_PSEL && I_PENABLE))
        else $error("pready does not follow psel and penable");
    reset_clear_a: assert property (disable iff (1'b0) I_SYS_RST |=>
        O_PAD_OUT == 2'h0 && O_PAD_OE == 2'h3 && O_REGISTERED_INPUT == 2'h0)
        else $error("reset state wrong");
    gsr_hold_a: assert property (!I_GLOBAL_SET_RESET_N [*2] |=>
        $stable({O_REGISTERED_INPUT, O_PAD_OUT, O_PAD_OE}))
        else $error("storage moved under global set/reset");
    lsr_hold_a: assert property (I_LOCAL_SET_RESET [*2] |=>
        $stable({O_REGISTERED_INPUT, O_PAD_OUT, O_PAD_OE}))
        else $error("storage moved under local set/reset");
    ce_freeze_a: assert property (!I_CE_IN && I_GLOBAL_SET_RESET_N
        && !I_LOCAL_SET_RESET |=> $stable(O_REGISTERED_INPUT))
        else $error("input register moved with enable low");
    bypass_sync_a: assert property (rc_q == 2'h3 |->
        O_COMB_INPUT_TO_CORE == $past(I_PAD_INPUT, 2)
        && O_CLOCK_NETWORK_INPUT == O_COMB_INPUT_TO_CORE)
        else $error("bypass path wrong");
    feed_track_a: assert property (rc_q == 2'h3 |->
        O_STROBE_DELAY_FEED == O_COMB_INPUT_TO_CORE[0])
        else $error("strobe feed wrong");
    slverr_set_a: assert property (I_PSEL && !I_PENABLE
        && I_PADDR == 12'h00c |=> O_PSLVERR && O_PRDATA == 32'h0)
        else $error("unmapped access not refused");
    slverr_clear_a: assert property (I_PSEL && !I_PENABLE
        && I_PADDR == 12'h000 |=> !O_PSLVERR)
        else $error("mapped access refused");
    gsr_c: cover property (!I_GLOBAL_SET_RESET_N [*2]);
    err_c: cover property (I_PSEL && I_PENABLE && O_PSLVERR);
    ddr_c: cover property ($changed(O_DUAL_RATE_INPUT_A));
endmodule

// ### bench/ioc_mem_model.sv
/* Source-synchronous memory model: drives strobe and data of a read.
   A rising i_start sends preamble, four half-beats and postamble. */
module ioc_mem_model (
    // Control
    input  logic       i_start,
    input  logic [7:0] i_burst,
    // Pins
    output logic       o_strobe,
    output logic       o_strobe_idle,
    output logic [1:0] o_dq,
    output logic       o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_strobe = 1'b1;
        o_strobe_idle = 1'b1;
        o_dq = 2'h2;
        o_done = 1'b0;
    end
    always @(posedge i_start) begin
        #3;
        o_done = 1'b0;
        o_strobe_idle = 1'b0;
        o_strobe = 1'b0;
        #160;
        for (int k = 0; k < 4; k++) begin
            o_dq = i_burst[2*k +: 2];
            #40;
            o_strobe = ~o_strobe;
            #40;
        end
        // Released data line has no pull: show the inverse
        o_dq = ~o_dq;
        o_done = 1'b1;
        #800;
        o_strobe = 1'b1;
        o_strobe_idle = 1'b1;
    end
endmodule

// ### bench/ioc_top_tb.sv
/* Self-checking bench for the I/O cell pair.
   Needs ioc_regs.vh on the include path and the memory model. */
`include "ioc_regs.vh"
module ioc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [17:0] ctrl;
        logic [1:0]  pad, dat, tc;
        logic [3:0]  gear;
        logic [1:0]  inp, out, om, oe;
    } ioc_row_t;
    ioc_row_t rows [6] = '{
        '{18'h00000, 2'h1, 2'h2, 2'h1, 4'h0, 2'h1, 2'h2, 2'h3, 2'h2},
        '{18'h00014, 2'h2, 2'h1, 2'h2, 4'h0, 2'h2, 2'h1, 2'h3, 2'h1},
        '{18'h0a008, 2'h3, 2'h3, 2'h0, 4'h0, 2'h3, 2'h3, 2'h3, 2'h3},
        '{18'h04801, 2'h1, 2'h1, 2'h2, 4'h0, 2'h3, 2'h1, 2'h3, 2'h1},
        '{18'h01002, 2'h1, 2'h0, 2'h0, 4'hf, 2'h3, 2'h1, 2'h1, 2'h3},
        '{18'h10003, 2'h2, 2'h1, 2'h0, 4'h0, 2'h2, 2'h1, 2'h3, 2'h3}};
    ioc_row_t r;
    logic I_SYS_CLK = 1'b0, I_CLK_ROUTE = 1'b0, I_SYS_RST, I_PSEL;
    logic I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, I_STROBE;
    logic I_EDGE_CLOCK_ONE, I_EDGE_CLOCK_TWO, I_STROBE_IDLE, I_CE_IN;
    logic I_SYNC_CLOCK_POLARITY, I_CE_OUT, I_LOCAL_SET_RESET;
    logic I_GLOBAL_SET_RESET_N, O_STROBE_DELAY_FEED, lerr, use_mem;
    logic mem_go, mem_done;
    logic [11:0] I_PADDR;
    logic [31:0] I_PWDATA, O_PRDATA, q;
    logic [1:0] I_PAD_INPUT, O_PAD_OUT, O_PAD_OE, I_OUT_DATA_NEG, v;
    logic [1:0] I_OUT_DATA_POS, I_TRI_CTRL_NEG, I_TRI_CTRL_POS, pad_r;
    logic [1:0] I_SDR_TRI_CTRL, O_COMB_INPUT_TO_CORE, O_REGISTERED_INPUT;
    logic [1:0] O_CLOCK_NETWORK_INPUT, O_DUAL_RATE_INPUT_A, mem_dq;
    logic [1:0] O_DUAL_RATE_INPUT_B, O_GEARBOX_POS_INPUT;
    logic [1:0] O_GEARBOX_NEG_INPUT;
    logic [3:0] I_DYNAMIC_DELAY_CTRL = 4'h3, I_GEAR_OUT_DATA;
    logic [2:0] ec_q = 3'h0;
    int num_errors = 0, samples_checked = 0;
    always #5 I_SYS_CLK = ~I_SYS_CLK;
    always #80 I_CLK_ROUTE = ~I_CLK_ROUTE;
    always @(posedge I_SYS_CLK) ec_q <= ec_q + 3'h1;
    assign I_EDGE_CLOCK_ONE = ec_q[1];
    assign I_EDGE_CLOCK_TWO = ec_q[2];
    assign I_PAD_INPUT = use_mem ? mem_dq : pad_r;
    ioc_top u_ioc_top (.*);
    ioc_mem_model u_ioc_mem_model (.i_start(mem_go), .i_burst(8'h9c),
        .o_strobe(I_STROBE), .o_strobe_idle(I_STROBE_IDLE),
        .o_dq(mem_dq), .o_done(mem_done));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_SYS_CLK);
        I_PENABLE <= 1'b1;
        do @(posedge I_SYS_CLK); while (O_PREADY !== 1'b1);
        q = O_PRDATA;
        lerr = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
        @(posedge I_SYS_CLK);
    endtask
    task automatic results();
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        results();
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {I_PSEL, I_PENABLE, I_PWRITE, I_LOCAL_SET_RESET, use_mem} = '0;
        {I_PADDR, I_PWDATA, I_SYNC_CLOCK_POLARITY, mem_go, pad_r} = '0;
        {I_OUT_DATA_NEG, I_OUT_DATA_POS, I_SDR_TRI_CTRL} = '0;
        {I_TRI_CTRL_NEG, I_TRI_CTRL_POS, I_GEAR_OUT_DATA} = '0;
        {I_SYS_RST, I_CE_IN, I_CE_OUT, I_GLOBAL_SET_RESET_N} = 4'hf;
        repeat (12) @(posedge I_SYS_CLK);
        I_SYS_RST <= 1'b0;
        @(posedge I_SYS_CLK);
        apb(1'b0, `IOC_ADDR_CTRL, 32'h0);
        check(q, 32'h0);
        apb(1'b0, `IOC_ADDR_INIT, 32'h0);
        check(q, 32'h0);
        apb(1'b0, `IOC_ADDR_STATUS, 32'h0);
        check(q & 32'hc00, 32'hc00);
        foreach (rows[i]) begin
            r = rows[i];
            pad_r <= r.pad;
            I_OUT_DATA_NEG <= r.dat;
            I_OUT_DATA_POS <= r.dat;
            I_TRI_CTRL_NEG <= r.tc;
            I_TRI_CTRL_POS <= r.tc;
            I_SDR_TRI_CTRL <= r.tc;
            I_GEAR_OUT_DATA <= r.gear;
            apb(1'b1, `IOC_ADDR_CTRL, {14'h0, r.ctrl});
            repeat (60) @(posedge I_SYS_CLK);
            case (r.ctrl[1:0])
                2'h0: v = O_REGISTERED_INPUT;
                2'h1: v = O_DUAL_RATE_INPUT_A;
                2'h2: v = O_GEARBOX_POS_INPUT & O_GEARBOX_NEG_INPUT;
                default: v = O_COMB_INPUT_TO_CORE;
            endcase
            check(v, r.inp);
            check(O_PAD_OUT & r.om, r.out & r.om);
            check(O_PAD_OE, r.oe);
        end
        apb(1'b1, `IOC_ADDR_CTRL, 32'hffffffff);
        apb(1'b0, `IOC_ADDR_CTRL, 32'h0);
        check(q, 32'h3ffff);
        apb(1'b0, 12'h00c, 32'h0);
        check({lerr, q}, {1'b1, 32'h0});
        apb(1'b1, `IOC_ADDR_STATUS, 32'hffffffff);
        check(lerr, 1'b0);
        // Frozen input register with enable low
        I_CE_IN <= 1'b0;
        apb(1'b1, `IOC_ADDR_CTRL, 32'h0);
        pad_r <= 2'h0;
        repeat (60) @(posedge I_SYS_CLK);
        check(O_REGISTERED_INPUT, 2'h3);
        I_CE_IN <= 1'b1;
        repeat (60) @(posedge I_SYS_CLK);
        check(O_REGISTERED_INPUT, 2'h0);
        apb(1'b1, `IOC_ADDR_INIT, 32'h7);
        {I_CE_IN, I_CE_OUT, I_GLOBAL_SET_RESET_N} <= 3'h0;
        repeat (20) @(posedge I_SYS_CLK);
        check({O_REGISTERED_INPUT, O_PAD_OUT, O_PAD_OE}, 6'h3c);
        I_GLOBAL_SET_RESET_N <= 1'b1;
        apb(1'b1, `IOC_ADDR_INIT, 32'h0);
        I_LOCAL_SET_RESET <= 1'b1;
        repeat (20) @(posedge I_SYS_CLK);
        check({O_REGISTERED_INPUT, O_PAD_OUT, O_PAD_OE}, 6'h03);
        {I_CE_IN, I_CE_OUT, I_LOCAL_SET_RESET} <= 3'h6;
        // Strobe-clocked read burst from the memory model
        I_SYNC_CLOCK_POLARITY <= 1'b1;
        use_mem <= 1'b1;
        apb(1'b1, `IOC_ADDR_CTRL, 32'h0000d);
        mem_go <= 1'b1;
        wait (mem_done === 1'b1);
        @(posedge I_SYS_CLK);
        mem_go <= 1'b0;
        repeat (40) @(posedge I_SYS_CLK);
        check(O_DUAL_RATE_INPUT_A, 2'h1);
        check(O_DUAL_RATE_INPUT_B, 2'h2);
        repeat (60) @(posedge I_SYS_CLK);
        results();
    end
endmodule
bind ioc_top ioc_top_props u_ioc_top_props (.*);
